// ===== src/dae_pkg.sv
package dae_pkg;
	// Instruction byte layout: [7:6] group, [5:3] op/dest, [2:0] src (misc: dest reg/pair, direct: op)
	localparam logic [1:0] GRP_COPY   = 2'h0;
	localparam logic [1:0] GRP_ARITH  = 2'h1;
	localparam logic [1:0] GRP_MISC   = 2'h2;
	localparam logic [1:0] GRP_DIRECT = 2'h3;
	localparam int IMM_BIT   = 3;
	localparam int CARRY_BIT = 4;
	localparam int SUB_BIT   = 5;

	localparam logic [2:0] MISC_LOAD_IMM8      = 3'h0;
	localparam logic [2:0] MISC_BUMP_UP        = 3'h1;
	localparam logic [2:0] MISC_BUMP_DOWN      = 3'h2;
	localparam logic [2:0] MISC_LOAD_PAIR_IMM  = 3'h3;
	localparam logic [2:0] MISC_PAIR_BUMP_UP   = 3'h4;
	localparam logic [2:0] MISC_LOAD_ACC_PAIR  = 3'h5;
	localparam logic [2:0] MISC_STORE_ACC_PAIR = 3'h6;

	localparam logic [2:0] DIR_LOAD_ACC  = 3'h0;
	localparam logic [2:0] DIR_STORE_ACC = 3'h1;
	localparam logic [2:0] DIR_LOAD_PTR  = 3'h2;
	localparam logic [2:0] DIR_STORE_PTR = 3'h3;
	localparam logic [2:0] DIR_SWAP      = 3'h4;

	localparam logic [2:0] REG_B   = 3'h0;
	localparam logic [2:0] REG_C   = 3'h1;
	localparam logic [2:0] REG_D   = 3'h2;
	localparam logic [2:0] REG_E   = 3'h3;
	localparam logic [2:0] REG_H   = 3'h4;
	localparam logic [2:0] REG_L   = 3'h5;
	localparam logic [2:0] REG_MEM = 3'h6;
	localparam logic [2:0] REG_A   = 3'h7;
	localparam logic [1:0] PAIR_SP = 2'h3;

	localparam int FL_CARRY = 0;
	localparam int FL_P     = 1;
	localparam int FL_HALF  = 2;
	localparam int FL_Z     = 3;
	localparam int FL_S     = 4;

	// State counts per instruction; one state per clock
	localparam logic [4:0] ST_REG    = 5'h04;
	localparam logic [4:0] ST_PBUMP  = 5'h06;
	localparam logic [4:0] ST_ONE    = 5'h07;
	localparam logic [4:0] ST_TWO    = 5'h0a;
	localparam logic [4:0] ST_THREE  = 5'h0d;
	localparam logic [4:0] ST_FOUR   = 5'h10;
	// Memory slots after the opcode fetch at state 0
	localparam logic [4:0] CNT_ZERO  = 5'h00;
	localparam logic [4:0] SLOT1     = 5'h04;
	localparam logic [4:0] SLOT2     = 5'h07;
	localparam logic [4:0] SLOT3     = 5'h0a;
	localparam logic [4:0] SLOT4     = 5'h0d;

	localparam logic [7:0]  RST_REG = 8'h00;
	localparam logic [15:0] RST_PC  = 16'h0000;
	localparam logic [15:0] RST_SP  = 16'h0000;
	localparam logic [4:0]  RST_FL  = 5'h00;

	typedef enum logic [1:0] {
		DAE_IDLE = 2'h1,
		DAE_EXEC = 2'h2
	} dae_phase_t;
endpackage

// ===== src/dae_alu_if.sv
`timescale 1ns/100ps
interface dae_alu_if;
	logic [7:0] a;
	logic [7:0] b;
	logic       cin;
	logic       sub;
	logic [7:0] res;
	logic       carry;
	logic       half_carry;
	logic       z;
	logic       s;
	logic       p;
	modport alu (input a, b, cin, sub, output res, carry, half_carry);
	modport flag (input res, output z, s, p);
endinterface

// ===== src/dae_alu.sv
`timescale 1ns/100ps
module dae_alu (
	dae_alu_if.alu u
);
	logic [7:0] bx;
	logic       ci;
	logic [4:0] lo;
	logic [4:0] hi;

	// Subtract as add of complement; carry out inverted is the borrow
	assign bx = u.sub ? ~u.b : u.b;
	assign ci = u.sub ? ~u.cin : u.cin;
	assign lo = {1'h0, u.a[3:0]} + {1'h0, bx[3:0]} + {4'h0, ci};
	assign hi = {1'h0, u.a[7:4]} + {1'h0, bx[7:4]} + {4'h0, lo[4]};
	assign u.res = {hi[3:0], lo[3:0]};
	assign u.half_carry = lo[4];
	assign u.carry      = hi[4] ^ u.sub;
endmodule // dae_alu

// ===== src/dae_flags.sv
`timescale 1ns/100ps
module dae_flags (
	dae_alu_if.flag u
);
	assign u.z = (u.res == 8'h00);
	assign u.s = u.res[7];
	assign u.p = ~^u.res;
endmodule // dae_flags

// ===== src/dae_exec.sv
`timescale 1ns/100ps
module dae_exec (
	input  wire logic        core_clk_i,
	input  wire logic        reset_i,
	input  wire logic        run_i,
	input  wire logic [7:0]  mem_rdata_i,
	output logic      [15:0] mem_addr_o,
	output logic             mem_rd_o,
	output logic             mem_wr_o,
	output logic      [7:0]  mem_wdata_o,
	output logic             instr_done_o,
	output logic      [7:0]  acc_o,
	output logic      [4:0]  flags_o,
	output logic      [15:0] pointer_o,
	output logic      [15:0] pc_o
);
	import dae_pkg::*;

	dae_phase_t  phase;
	logic [4:0]  cnt;
	logic [4:0]  next_cnt;
	logic [4:0]  states;
	logic        done;
	logic        go_fetch;
	logic [7:0]  ir;
	logic [7:0]  lo_byte;
	logic [7:0]  hi_byte;
	logic [15:0] md16;
	logic [7:0]  md;
	logic [7:0]  rf [8];
	logic [15:0] sp;
	logic [15:0] pc;
	logic [4:0]  fl;
	logic        src_pc;
	logic [1:0]  grp;
	logic [2:0]  f3;
	logic [2:0]  r3;
	logic [1:0]  pr;
	logic        is_copy;
	logic        is_ar;
	logic        is_misc;
	logic        is_dir;
	logic        r_m;
	logic        bump;
	logic        needs_opnd;
	logic        two_opnd;
	logic [15:0] hl;
	logic [15:0] dir;
	logic [15:0] pair_val;
	logic [15:0] pair_new;
	logic        next_rd;
	logic        next_wr;
	logic        next_src_pc;
	logic [15:0] next_addr;
	logic [7:0]  next_wdata;

	dae_alu_if alu_bus ();
	dae_alu    u_alu   (.u(alu_bus));
	dae_flags  u_flags (.u(alu_bus));

	assign grp      = ir[7:6];
	assign f3       = ir[5:3];
	assign r3       = ir[2:0];
	assign pr       = ir[1:0];
	assign is_copy  = (grp == GRP_COPY);
	assign is_ar    = (grp == GRP_ARITH);
	assign is_misc  = (grp == GRP_MISC);
	assign is_dir   = (grp == GRP_DIRECT);
	assign r_m      = (r3 == REG_MEM);
	assign bump     = is_misc && (f3 == MISC_BUMP_UP || f3 == MISC_BUMP_DOWN);
	assign md       = md16[15:8];
	assign hl       = {rf[REG_H], rf[REG_L]};
	assign dir      = {hi_byte, lo_byte};
	assign pair_val = (pr == PAIR_SP) ? sp : {rf[{pr, 1'h0}], rf[{pr, 1'h1}]};
	assign pair_new = (f3 == MISC_LOAD_PAIR_IMM) ? dir
		: pair_val + 16'h0001;
	assign needs_opnd = (is_ar && ir[IMM_BIT])
		|| (is_misc && (f3 == MISC_LOAD_IMM8 || f3 == MISC_LOAD_PAIR_IMM))
		|| (is_dir && r3 != DIR_SWAP);
	assign two_opnd = (is_misc && f3 == MISC_LOAD_PAIR_IMM)
		|| (is_dir && r3 != DIR_SWAP);

	// Instruction length in states; the opcode is valid from state 1 on
	always_comb begin
		states = ST_REG;
		case (grp)
			GRP_COPY:  if (r_m || f3 == REG_MEM) states = ST_ONE;
			GRP_ARITH: if (r_m || ir[IMM_BIT]) states = ST_ONE;
			GRP_MISC: begin
				case (f3)
					MISC_LOAD_IMM8:    states = r_m ? ST_TWO : ST_ONE;
					MISC_BUMP_UP,
					MISC_BUMP_DOWN:    states = r_m ? ST_TWO : ST_REG;
					MISC_LOAD_PAIR_IMM: states = ST_TWO;
					MISC_PAIR_BUMP_UP: states = ST_PBUMP;
					default:           states = ST_ONE;
				endcase
			end
			default: begin
				if (r3 == DIR_LOAD_ACC || r3 == DIR_STORE_ACC)
					states = ST_THREE;
				else if (r3 == DIR_LOAD_PTR || r3 == DIR_STORE_PTR)
					states = ST_FOUR;
			end
		endcase
	end

	assign done         = (phase == DAE_EXEC) && (cnt == states - 5'h01);
	assign go_fetch     = run_i && (phase == DAE_IDLE || done);
	assign next_cnt     = (phase == DAE_EXEC && !done) ? cnt + 5'h01 : CNT_ZERO;
	assign instr_done_o = done;

	// Run control; run_i is only looked at between instructions
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			phase <= DAE_IDLE;
			cnt   <= CNT_ZERO;
		end else begin
			cnt <= next_cnt;
			case (phase)
				DAE_IDLE: if (run_i) phase <= DAE_EXEC;
				DAE_EXEC: if (done && !run_i) phase <= DAE_IDLE;
				default:  phase <= DAE_IDLE;
			endcase
		end
	end

	// Plan the access for the next state so the bus pins come from flops
	always_comb begin
		next_rd     = 1'h0;
		next_wr     = 1'h0;
		next_src_pc = 1'h0;
		next_addr   = pc;
		next_wdata  = 8'h00;
		if (go_fetch) begin
			next_rd = 1'h1;
		end else if (phase == DAE_EXEC && !done) begin
			if (next_cnt == SLOT1) begin
				if (needs_opnd) begin
					next_rd     = 1'h1;
					next_src_pc = 1'h1;
				end else if (is_copy && r_m) begin
					next_rd   = 1'h1;
					next_addr = hl;
				end else if (is_copy && f3 == REG_MEM) begin
					next_wr    = 1'h1;
					next_addr  = hl;
					next_wdata = rf[r3];
				end else if ((is_ar || bump) && r_m) begin
					next_rd   = 1'h1;
					next_addr = hl;
				end else if (is_misc && f3 == MISC_LOAD_ACC_PAIR) begin
					next_rd   = 1'h1;
					next_addr = pair_val;
				end else if (is_misc && f3 == MISC_STORE_ACC_PAIR) begin
					next_wr    = 1'h1;
					next_addr  = pair_val;
					next_wdata = rf[REG_A];
				end
			end else if (next_cnt == SLOT2) begin
				if (two_opnd) begin
					next_rd     = 1'h1;
					next_src_pc = 1'h1;
				end else if (is_misc && f3 == MISC_LOAD_IMM8 && r_m) begin
					next_wr    = 1'h1;
					next_addr  = hl;
					next_wdata = lo_byte;
				end else if (bump && r_m) begin
					next_wr    = 1'h1;
					next_addr  = hl;
					next_wdata = alu_bus.res;
				end
			end else if (next_cnt == SLOT3 && is_dir) begin
				next_addr  = dir;
				next_rd    = (r3 == DIR_LOAD_ACC || r3 == DIR_LOAD_PTR);
				next_wr    = (r3 == DIR_STORE_ACC || r3 == DIR_STORE_PTR);
				next_wdata = (r3 == DIR_STORE_PTR) ? rf[REG_L] : rf[REG_A];
			end else if (next_cnt == SLOT4 && is_dir) begin
				next_addr  = dir + 16'h0001;
				next_rd    = (r3 == DIR_LOAD_PTR);
				next_wr    = (r3 == DIR_STORE_PTR);
				next_wdata = rf[REG_H];
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			mem_rd_o    <= 1'h0;
			mem_wr_o    <= 1'h0;
			src_pc      <= 1'h0;
			mem_addr_o  <= RST_PC;
			mem_wdata_o <= RST_REG;
		end else begin
			mem_rd_o    <= next_rd;
			mem_wr_o    <= next_wr;
			src_pc      <= next_src_pc;
			mem_addr_o  <= next_addr;
			mem_wdata_o <= next_wdata;
		end
	end

	// Read data is taken at the end of the state in which the read stands
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			ir      <= RST_REG;
			lo_byte <= RST_REG;
			hi_byte <= RST_REG;
			md16    <= RST_PC;
			pc      <= RST_PC;
		end else if (mem_rd_o) begin
			if (cnt == CNT_ZERO) begin
				ir <= mem_rdata_i;
				pc <= pc + 16'h0001;
			end else if (src_pc) begin
				if (cnt == SLOT1)
					lo_byte <= mem_rdata_i;
				else
					hi_byte <= mem_rdata_i;
				pc <= pc + 16'h0001;
			end else begin
				md16 <= {mem_rdata_i, md16[15:8]};
			end
		end
	end

	always_comb begin
		alu_bus.a   = rf[REG_A];
		alu_bus.b   = 8'h00;
		alu_bus.cin = 1'h0;
		alu_bus.sub = 1'h0;
		if (is_ar) begin
			alu_bus.b   = ir[IMM_BIT] ? lo_byte : (r_m ? md : rf[r3]);
			alu_bus.cin = ir[CARRY_BIT] & fl[FL_CARRY];
			alu_bus.sub = ir[SUB_BIT];
		end else if (bump) begin
			alu_bus.a   = r_m ? md : rf[r3];
			alu_bus.b   = 8'h01;
			alu_bus.sub = (f3 == MISC_BUMP_DOWN);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			for (int i = 0; i < 8; i++)
				rf[i] <= RST_REG;
			sp <= RST_SP;
		end else if (done) begin
			case (grp)
				GRP_COPY: begin
					if (f3 != REG_MEM)
						rf[f3] <= r_m ? md : rf[r3];
				end
				GRP_ARITH: rf[REG_A] <= alu_bus.res;
				GRP_MISC: begin
					case (f3)
						MISC_LOAD_IMM8: if (!r_m) rf[r3] <= lo_byte;
						MISC_BUMP_UP,
						MISC_BUMP_DOWN: if (!r_m) rf[r3] <= alu_bus.res;
						MISC_LOAD_PAIR_IMM,
						MISC_PAIR_BUMP_UP: begin
							if (pr == PAIR_SP)
								sp <= pair_new;
							else begin
								rf[{pr, 1'h0}] <= pair_new[15:8];
								rf[{pr, 1'h1}] <= pair_new[7:0];
							end
						end
						MISC_LOAD_ACC_PAIR: rf[REG_A] <= md;
						default: ;
					endcase
				end
				default: begin
					case (r3)
						DIR_LOAD_ACC: rf[REG_A] <= md;
						DIR_LOAD_PTR: begin
							rf[REG_H] <= md16[15:8];
							rf[REG_L] <= md16[7:0];
						end
						DIR_SWAP: begin
							rf[REG_H] <= rf[REG_D];
							rf[REG_D] <= rf[REG_H];
							rf[REG_L] <= rf[REG_E];
							rf[REG_E] <= rf[REG_L];
						end
						default: ;
					endcase
				end
			endcase
		end
	end

	// Moves and pair ops never reach the flags
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			fl <= RST_FL;
		end else if (done && (is_ar || bump)) begin
			fl[FL_Z]  <= alu_bus.z;
			fl[FL_S]  <= alu_bus.s;
			fl[FL_P]  <= alu_bus.p;
			fl[FL_HALF] <= alu_bus.half_carry;
			if (is_ar)
				fl[FL_CARRY] <= alu_bus.carry;
		end
	end

	assign acc_o     = rf[REG_A];
	assign flags_o   = fl;
	assign pointer_o = hl;
	assign pc_o      = pc;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	sequence s_fetch;
		phase == DAE_EXEC && cnt == CNT_ZERO && mem_rd_o;
	endsequence
	sequence s_decoded(logic c);
		s_fetch ##1 c;
	endsequence

	chk_copy_mem_len: assert property (
		s_decoded(is_copy && r_m && f3 != REG_MEM) |->
			##5 (done && $past(mem_rd_o, 2)))
		else $error("copy from memory length wrong");
	chk_store_ptr_addr: assert property (
		mem_wr_o && is_copy && f3 == REG_MEM && cnt == SLOT1 |->
			mem_addr_o == hl && mem_wdata_o == rf[r3])
		else $error("store via pointer address or data wrong");
	chk_imm_mem_len: assert property (
		s_decoded(is_misc && f3 == MISC_LOAD_IMM8 && r_m) |->
			##8 (done && $past(mem_wr_o, 2)))
		else $error("immediate to memory timing wrong");
	chk_direct_load_len: assert property (
		s_decoded(is_dir && r3 == DIR_LOAD_ACC) |-> ##11 done)
		else $error("direct load not 13 states");
	chk_direct_addr: assert property (
		mem_rd_o && is_dir && cnt == SLOT3 |-> mem_addr_o == dir)
		else $error("direct data address wrong");
	chk_ptr_load_len: assert property (
		s_decoded(is_dir && r3 == DIR_LOAD_PTR) |-> !done [*8] ##7 done)
		else $error("pointer direct load not 16 states");
	chk_move_flags: assert property (
		done && (is_copy || is_dir) |=> $stable(fl))
		else $error("move changed a flag");
	chk_bump_carry: assert property (
		done && bump |=> fl[FL_CARRY] == $past(fl[FL_CARRY]))
		else $error("bump changed carry");
	chk_zero_flag: assert property (
		done && is_ar |=> fl[FL_Z] == (rf[REG_A] == 8'h00)
			&& fl[FL_S] == rf[REG_A][7] && fl[FL_P] == ~^rf[REG_A])
		else $error("zero sign or parity wrong");
	chk_pair_wrap: assert property (
		done && is_misc && f3 == MISC_PAIR_BUMP_UP && pr == 2'h2 |=>
			hl == $past(hl) + 16'h0001)
		else $error("pair bump wrong");
	chk_swap_regs: assert property (
		done && is_dir && r3 == DIR_SWAP |=>
			rf[REG_H] == $past(rf[REG_D]) && rf[REG_E] == $past(rf[REG_L]))
		else $error("swap wrong");
endmodule // dae_exec

// ===== testbench/dae_mem_model.sv
`timescale 1ns/100ps
module dae_mem_model (
	input  wire logic        core_clk_i,
	input  wire logic        mem_rd_i,
	input  wire logic        mem_wr_i,
	input  wire logic [15:0] mem_addr_i,
	input  wire logic [7:0]  mem_wdata_i,
	output logic      [7:0]  mem_rdata_o
);
	logic [7:0] mem [65536];
	logic [7:0] junk = 8'h5a;

	// Zero wait states: data answered in the strobe cycle
	always @(posedge core_clk_i) begin
		junk <= ~junk;
		if (mem_wr_i)
			mem[mem_addr_i] <= mem_wdata_i;
	end

	// Outside a read strobe the bus shows a changing pattern, never old data
	assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i] : junk;
endmodule // dae_mem_model

// ===== testbench/tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
	$display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
	import dae_pkg::*;
	logic        core_clk = 1'b0;
	logic        reset_i  = 1'b1;
	logic        run_i    = 1'b0;
	logic [7:0]  rdata;
	logic [15:0] addr;
	logic        rd;
	logic        wr;
	logic [7:0]  wdata;
	logic        done;
	logic [7:0]  acc;
	logic [4:0]  flags;
	logic [15:0] ptr;
	logic [15:0] pc;
	int          fails    = 0;
	int          checked  = 0;
	int          lens[$];
	logic [7:0]  aq[$];
	logic [4:0]  fq[$];

	always #20 core_clk = ~core_clk;

	dae_exec i_dut (
		.core_clk_i  (core_clk),
		.reset_i     (reset_i),
		.run_i       (run_i),
		.mem_rdata_i (rdata),
		.mem_addr_o  (addr),
		.mem_rd_o    (rd),
		.mem_wr_o    (wr),
		.mem_wdata_o (wdata),
		.instr_done_o(done),
		.acc_o       (acc),
		.flags_o     (flags),
		.pointer_o   (ptr),
		.pc_o        (pc)
	);

	dae_mem_model i_mem (
		.core_clk_i (core_clk),
		.mem_rd_i   (rd),
		.mem_wr_i   (wr),
		.mem_addr_i (addr),
		.mem_wdata_i(wdata),
		.mem_rdata_o(rdata)
	);

	task automatic print_verdict();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Zeroed memory decodes as a harmless register copy, so the core runs on past the program end
	task automatic restart(input logic [7:0] prog[$]);
		@(posedge core_clk);
		reset_i <= 1'b1;
		run_i <= 1'b0;
		for (int i = 0; i < 65536; i++)
			i_mem.mem[i] = 8'h00;
		foreach (prog[i])
			i_mem.mem[i] = prog[i];
		repeat (5) @(posedge core_clk);
		reset_i <= 1'b0;
	endtask

	// Records each instruction's state count and the results it leaves
	task automatic run(input int n);
		int cnt;
		int dn;
		int lim;
		logic go;
		logic pd;
		lens.delete();
		aq.delete();
		fq.delete();
		cnt = 0;
		dn = 0;
		go = 1'b0;
		pd = 1'b0;
		@(posedge core_clk);
		run_i <= 1'b1;
		for (lim = 0; lim < 3000; lim++) begin
			@(negedge core_clk);
			if (pd) begin
				aq.push_back(acc);
				fq.push_back(flags);
				if (dn == n)
					break;
			end
			pd = 1'b0;
			if (!go && rd === 1'b1)
				go = 1'b1;
			if (go)
				cnt++;
			if (done === 1'b1) begin
				lens.push_back(cnt);
				cnt = 0;
				dn++;
				pd = 1'b1;
			end
		end
		if (lim >= 3000) begin
			fails++;
			$display("[ERR] %0t run timed out", $time);
			print_verdict();
		end
	endtask

	function automatic logic [12:0] ref_arith(input logic [7:0] op,
		input logic [7:0] a, input logic [7:0] b, input logic cf);
		logic [8:0] s;
		logic [4:0] h;
		logic       c;
		c = op[4] & cf;
		if (op[5]) begin
			s = {1'b0, a} + {1'b0, ~b} + {8'h00, ~c};
			h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ~c};
			s[8] = ~s[8];
		end else begin
			s = {1'b0, a} + {1'b0, b} + {8'h00, c};
			h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
		end
		return {s[7], s[7:0] == 8'h00, h[4], ~^s[7:0], s[8], s[7:0]};
	endfunction

	task automatic t_moves();
		restart('{8'h48, 8'h80, 8'h84, 8'h12, 8'h85, 8'h34, 8'h86, 8'h5a,
			8'h06, 8'h38, 8'h35});
		run(7);
		`CHK(aq[0], 8'h80)
		`CHK(lens[0], 7)
		`CHK(lens[1], 7)
		`CHK(lens[3], 10)
		`CHK(i_mem.mem[16'h1234], 8'h34)
		`CHK(lens[4], 7)
		`CHK(lens[5], 4)
		`CHK(lens[6], 7)
		`CHK(acc, 8'h5a)
		`CHK(ptr, 16'h1234)
		`CHK(pc, 16'h000b)
		`CHK(fq[6], 5'h10)
		$display("test moves done");
	endtask

	task automatic t_direct();
		restart('{8'h9a, 8'h78, 8'h56, 8'hc3, 8'h00, 8'h30, 8'hc0, 8'h01,
			8'h30, 8'hc1, 8'h10, 8'h30, 8'hc2, 8'h00, 8'h40, 8'ha2, 8'hc4,
			8'hb1, 8'ha8});
		i_mem.mem[16'h4000] = 8'hcd;
		i_mem.mem[16'h4001] = 8'hab;
		run(9);
		`CHK(lens[0], 10)
		`CHK(i_mem.mem[16'h3000], 8'h78)
		`CHK(i_mem.mem[16'h3001], 8'h56)
		`CHK(lens[1], 16)
		`CHK(aq[2], 8'h56)
		`CHK(lens[2], 13)
		`CHK(i_mem.mem[16'h3010], 8'h56)
		`CHK(lens[3], 13)
		`CHK(lens[4], 16)
		`CHK(lens[5], 6)
		`CHK(lens[6], 4)
		`CHK(ptr, 16'h0000)
		`CHK(pc, 16'h0013)
		`CHK(i_mem.mem[16'habce], 8'h56)
		`CHK(lens[7], 7)
		`CHK(acc, 8'h9a)
		`CHK(fq[8], 5'h00)
		$display("test direct done");
	endtask

	task automatic t_arith();
		logic [7:0]  ops[4] = '{8'h48, 8'h58, 8'h68, 8'h78};
		logic [7:0]  as[4] = '{8'h0f, 8'hff, 8'h00, 8'h10};
		logic [7:0]  bs[4] = '{8'h01, 8'h00, 8'h01, 8'h0f};
		logic [12:0] e;
		for (int i = 0; i < 8; i++) begin
			restart('{8'h87, 8'hff, 8'h48, 8'(i % 2), 8'h87, as[i / 2],
				ops[i / 2], bs[i / 2]});
			run(4);
			e = ref_arith(ops[i / 2], as[i / 2], bs[i / 2], 1'(i % 2));
			`CHK(acc, e[7:0])
			`CHK(flags, e[12:8])
			`CHK(lens[3], 7)
		end
		$display("test arith done");
	endtask

	task automatic t_bump();
		restart('{8'h84, 8'h20, 8'h85, 8'h00, 8'h86, 8'h0f, 8'h8e, 8'h76,
			8'h80, 8'hff, 8'h88, 8'h38, 8'h97, 8'h9a, 8'hff, 8'hff, 8'ha2,
			8'h50});
		run(12);
		`CHK(i_mem.mem[16'h2000], 8'h10)
		`CHK(fq[3], 5'h04)
		`CHK(lens[3], 10)
		`CHK(aq[4], 8'hf0)
		`CHK(fq[4], 5'h17)
		`CHK(lens[4], 7)
		`CHK(fq[6], 5'h0f)
		`CHK(aq[7], 8'h00)
		`CHK(lens[6], 4)
		`CHK(aq[8], 8'hff)
		`CHK(fq[8], 5'h13)
		`CHK(ptr, 16'h0000)
		`CHK(fq[10], 5'h13)
		`CHK(aq[11], 8'h00)
		`CHK(fq[11], 5'h0f)
		`CHK(lens[11], 4)
		$display("test bump done");
	endtask

	initial begin
		repeat (5) @(posedge core_clk);
		t_moves();
		t_direct();
		t_arith();
		t_bump();
		print_verdict();
	end
endmodule // tb_top
